// [inc/icv_defs.vh]
// Constants for the interrupt classification and vectoring block.
// Assumes 20-bit byte addresses and a 20 MHz CPU clock.
`ifndef ICV_DEFS_VH
`define ICV_DEFS_VH

// Fixed vector table
`define ICV_VEC_UNDEF      20'hfffdc
`define ICV_VEC_OVF        20'hfffe0
`define ICV_VEC_BRK        20'hfffe4
`define ICV_VEC_AMATCH     20'hfffe8
`define ICV_VEC_SSTEP      20'hfffec
`define ICV_VEC_OSC_WDT    20'hffff0
`define ICV_VEC_DBG        20'hffff4
`define ICV_VEC_NMI        20'hffff8
`define ICV_VEC_RESET      20'hffffc
`define ICV_TBL_LO         20'hfffdc
`define ICV_TBL_HI         20'hfffff
`define ICV_VEC_BYTES      3'h4

// Trap number limits
`define ICV_TRAP_MAX       6'h3f
`define ICV_TRAP_PERIPH_HI 6'h1f
`define ICV_TRAP_UFLAG_BIT 5

// Register offsets (word addresses, one per 32-bit register)
`define ICV_REG_STATUS     4'h0
`define ICV_REG_ENABLE     4'h1
`define ICV_REG_CLEAR      4'h2
`define ICV_REG_MATCH_EN   4'h3
`define ICV_REG_OSC_FLAG   4'h4
`define ICV_REG_MATCH0     4'h5
`define ICV_REG_MATCH1     4'h6
`define ICV_REG_MATCH2     4'h7
`define ICV_REG_MATCH3     4'h8
`define ICV_REG_VECTOR     4'h9

// Status bit positions
`define ICV_ST_TRAP        0
`define ICV_ST_NMI         1
`define ICV_ST_WDT         2
`define ICV_ST_OSC         3
`define ICV_ST_AMATCH      4
`define ICV_ST_PERIPH      5
`define ICV_ST_W           6

// Reset values
`define ICV_RST_ENABLE     6'h00
`define ICV_RST_MATCH_EN   4'h0
`define ICV_RST_MATCH      20'h00000

`endif

// [src/icv_top.v]
// Interrupt classification and vectoring unit: traps, special and
// peripheral interrupts to fixed or relocatable vector and stack select decisions.
// Assumes CPU sequencer holds take requests until ack, and an
// Avalon-MM master for the register file; all inputs synchronous.
//
// Functional notes
// - Trap instructions ignore enable flag and priority
// - Illegal opcode trap vectors at FFFDCh
// - Overflow trap only when overflow flag 1
// - Breakpoint trap vectors at FFFE4h
// - Trap numbers 0-63; 0-31 share peripheral vectors
// - Traps 0-31 push and clear stack flag
// - Traps 32-63 keep stack flag
// - Falling edge on NMI pin raises NMI
// - Address match before enabled matching instruction
// - Pin, debug, watchdog, osc, step, match non-maskable
// - Peripherals taken only under enable and level
// - Four-byte vector holds handler address; branch there
// - Fixed table FFFDCh-FFFFFh, reset at FFFFCh
// - Osc-stop and watchdog share FFFF0h
// - Osc flag set blocks further; write 0 re-enables
`timescale 1ns/1ps
`default_nettype none
`include "icv_defs.vh"

module icv_top (
    input  wire        clk,
    input  wire        sys_rst,
    // Avalon-MM slave
    input  wire [3:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    output reg  [31:0] avs_readdata,
    output wire        avs_waitrequest,
    // Instruction sequencer
    input  wire        instr_valid,
    input  wire [19:0] instr_addr,
    input  wire        illegal_op_instruction,
    input  wire        overflow_trap_instruction,
    input  wire        breakpoint_trap_instruction,
    input  wire        numbered_trap_instruction,
    input  wire [5:0]  trap_number,
    input  wire        overflow_flag,
    input  wire        interrupt_enable_flag,
    input  wire [2:0]  cpu_priority_level,
    input  wire        stack_select_flag,
    input  wire        return_from_interrupt,
    input  wire        restored_stack_flag,
    // Requesters
    input  wire        nmi_pin,
    input  wire        debugger_break_request,
    input  wire        watchdog_request,
    input  wire        osc_stop_event,
    input  wire        single_step_request,
    input  wire        periph_request,
    input  wire [4:0]  periph_number,
    input  wire [2:0]  periph_level,
    input  wire [19:0] relocatable_base,
    // Sequencer answer
    input  wire        take_ack,
    output reg         take_valid,
    output reg  [19:0] vector_addr_ff,
    output reg         vector_fixed_ff,
    output reg         non_maskable_ff,
    output reg         push_stack_flag_ff,
    output reg         stack_select_ff,
    output wire        irq
);

////////////////////////////////////////////////////////////////////////
// Request capture

reg        nmi_pin_ff;
reg        osc_stop_detect_flag;
reg [3:0]  match_enable_ff;
reg [19:0] match_address_regs [0:3];
reg [`ICV_ST_W-1:0] status_ff;
reg [`ICV_ST_W-1:0] enable_ff;
reg        nmi_pend_ff;
reg        osc_pend_ff;
integer    i;

wire nmi_fall = nmi_pin_ff & ~nmi_pin;
wire osc_evt  = osc_stop_event & ~osc_stop_detect_flag;

// One comparator per match register; the loop index stays private to reset
wire [3:0] match_hit;
genvar     g;
generate
    for (g = 0; g < 4; g = g + 1) begin : g_match
        icv_addr_cmp u_cmp (
            .enable   (match_enable_ff[g]),
            .valid    (instr_valid),
            .addr     (instr_addr),
            .match_at (match_address_regs[g]),
            .hit      (match_hit[g])
        );
    end
endgenerate
wire amatch = |match_hit;

wire sw_trap = illegal_op_instruction | breakpoint_trap_instruction
             | (overflow_trap_instruction & overflow_flag)
             | numbered_trap_instruction;
wire periph_ok = periph_request & interrupt_enable_flag
               & (periph_level > cpu_priority_level);

////////////////////////////////////////////////////////////////////////
// Selection, fixed priority among present requests

reg        sel_any;
reg [19:0] sel_vec;
reg        sel_fixed;
reg        sel_nm;
reg        sel_push;
reg [2:0]  sel_src;
localparam SRC_TRAP = 3'h0;
localparam SRC_NMI  = 3'h1;
localparam SRC_OW   = 3'h2;
localparam SRC_AM   = 3'h3;
localparam SRC_PER  = 3'h4;
localparam SRC_OTH  = 3'h5;

always @* begin
    sel_any   = 1'b1;
    sel_vec   = `ICV_VEC_RESET;
    sel_fixed = 1'b1;
    sel_nm    = 1'b1;
    sel_push  = 1'b0;
    sel_src   = SRC_OTH;
    if (illegal_op_instruction) begin
        sel_vec = `ICV_VEC_UNDEF;
        sel_src = SRC_TRAP;
    end else if (overflow_trap_instruction && overflow_flag) begin
        sel_vec = `ICV_VEC_OVF;
        sel_src = SRC_TRAP;
    end else if (breakpoint_trap_instruction) begin
        sel_vec = `ICV_VEC_BRK;
        sel_src = SRC_TRAP;
    end else if (numbered_trap_instruction) begin
        // Number times four into relocatable table
        sel_vec   = relocatable_base + {12'h000, trap_number, 2'b00};
        sel_fixed = 1'b0;
        sel_push  = ~trap_number[`ICV_TRAP_UFLAG_BIT];
        sel_src   = SRC_TRAP;
    end else if (nmi_pend_ff) begin
        sel_vec = `ICV_VEC_NMI;
        sel_src = SRC_NMI;
    end else if (debugger_break_request) begin
        sel_vec = `ICV_VEC_DBG;
    end else if (watchdog_request || osc_pend_ff) begin
        sel_vec = `ICV_VEC_OSC_WDT;
        sel_src = SRC_OW;
    end else if (single_step_request) begin
        sel_vec = `ICV_VEC_SSTEP;
    end else if (amatch) begin
        sel_vec = `ICV_VEC_AMATCH;
        sel_src = SRC_AM;
    end else if (periph_ok) begin
        // Peripheral shares numbered vector
        sel_vec   = relocatable_base + {13'h0000, periph_number, 2'b00};
        sel_fixed = 1'b0;
        sel_nm    = 1'b0;
        sel_push  = 1'b1;
        sel_src   = SRC_PER;
    end else begin
        sel_any = 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////
// Answer to sequencer, held until acknowledged

localparam ST_IDLE = 2'b01;
localparam ST_HOLD = 2'b10;
reg [1:0] state_ff;
reg [1:0] nxt_state;

always @* begin
    case (state_ff)
        ST_IDLE: nxt_state = sel_any ? ST_HOLD : ST_IDLE;
        ST_HOLD: nxt_state = take_ack ? ST_IDLE : ST_HOLD;
        default: nxt_state = ST_IDLE;
    endcase
end

always @* begin
    take_valid = (state_ff == ST_HOLD);
end

wire take_go = (state_ff == ST_IDLE) && sel_any;

always @(posedge clk) begin
    if (sys_rst) begin
        state_ff           <= ST_IDLE;
        vector_addr_ff     <= `ICV_VEC_RESET;
        vector_fixed_ff    <= 1'b1;
        non_maskable_ff    <= 1'b1;
        push_stack_flag_ff <= 1'b0;
        stack_select_ff    <= 1'b0;
    end else begin
        state_ff <= nxt_state;
        if (take_go) begin
            vector_addr_ff     <= sel_vec;
            vector_fixed_ff    <= sel_fixed;
            non_maskable_ff    <= sel_nm;
            push_stack_flag_ff <= sel_push;
        end
        // Stack flag tracks CPU, forced to handler stack on push
        if (take_go && sel_push) begin
            stack_select_ff <= 1'b0;
        end else if (return_from_interrupt) begin
            stack_select_ff <= restored_stack_flag;
        end else if (state_ff == ST_IDLE) begin
            stack_select_ff <= stack_select_flag;
        end
    end
end

////////////////////////////////////////////////////////////////////////
// Pending latches, status, registers

wire bus_wr = avs_write;
wire osc_clr = bus_wr && avs_address == `ICV_REG_OSC_FLAG && !avs_writedata[0];

wire [`ICV_ST_W-1:0] events = {periph_ok & take_go & (sel_src == SRC_PER),
                               amatch & take_go & (sel_src == SRC_AM),
                               osc_evt, watchdog_request, nmi_fall,
                               take_go & (sel_src == SRC_TRAP)};

always @(posedge clk) begin
    if (sys_rst) begin
        nmi_pin_ff           <= 1'b1;
        nmi_pend_ff          <= 1'b0;
        osc_pend_ff          <= 1'b0;
        osc_stop_detect_flag <= 1'b0;
        match_enable_ff      <= `ICV_RST_MATCH_EN;
        enable_ff            <= `ICV_RST_ENABLE;
        status_ff            <= {`ICV_ST_W{1'b0}};
        for (i = 0; i < 4; i = i + 1) begin
            match_address_regs[i] <= `ICV_RST_MATCH;
        end
    end else begin
        nmi_pin_ff <= nmi_pin;
        if (nmi_fall) begin
            nmi_pend_ff <= 1'b1;
        end else if (take_go && sel_src == SRC_NMI) begin
            nmi_pend_ff <= 1'b0;
        end
        if (osc_evt) begin
            osc_pend_ff <= 1'b1;
        end else if (take_go && sel_src == SRC_OW) begin
            osc_pend_ff <= 1'b0;
        end
        // Set wins over software clear
        if (osc_evt) begin
            osc_stop_detect_flag <= 1'b1;
        end else if (osc_clr) begin
            osc_stop_detect_flag <= 1'b0;
        end
        status_ff <= (status_ff & ~((bus_wr && avs_address == `ICV_REG_CLEAR)
                     ? avs_writedata[`ICV_ST_W-1:0] : {`ICV_ST_W{1'b0}})) | events;
        if (bus_wr) begin
            case (avs_address)
                `ICV_REG_ENABLE:   enable_ff <= avs_writedata[`ICV_ST_W-1:0];
                `ICV_REG_MATCH_EN: match_enable_ff <= avs_writedata[3:0];
                `ICV_REG_MATCH0:   match_address_regs[0] <= avs_writedata[19:0];
                `ICV_REG_MATCH1:   match_address_regs[1] <= avs_writedata[19:0];
                `ICV_REG_MATCH2:   match_address_regs[2] <= avs_writedata[19:0];
                `ICV_REG_MATCH3:   match_address_regs[3] <= avs_writedata[19:0];
                default: ;
            endcase
        end
    end
end

assign irq = |(status_ff & enable_ff);
// Zero-wait slave keeps the master simple
assign avs_waitrequest = 1'b0;

always @* begin
    case (avs_address)
        `ICV_REG_STATUS:   avs_readdata = {26'h0000000, status_ff};
        `ICV_REG_ENABLE:   avs_readdata = {26'h0000000, enable_ff};
        `ICV_REG_MATCH_EN: avs_readdata = {28'h0000000, match_enable_ff};
        `ICV_REG_OSC_FLAG: avs_readdata = {31'h00000000, osc_stop_detect_flag};
        `ICV_REG_MATCH0:   avs_readdata = {12'h000, match_address_regs[0]};
        `ICV_REG_MATCH1:   avs_readdata = {12'h000, match_address_regs[1]};
        `ICV_REG_MATCH2:   avs_readdata = {12'h000, match_address_regs[2]};
        `ICV_REG_MATCH3:   avs_readdata = {12'h000, match_address_regs[3]};
        `ICV_REG_VECTOR:   avs_readdata = {12'h000, vector_addr_ff};
        default:           avs_readdata = 32'h00000000;
    endcase
end

endmodule

////////////////////////////////////////////////////////////////////////
// Address match comparator, instantiated once per match register

module icv_addr_cmp #(
    parameter AW = 20
) (
    input  wire          enable,
    input  wire          valid,
    input  wire [AW-1:0] addr,
    input  wire [AW-1:0] match_at,
    output wire          hit
);
// Enable gates the compare so a cleared entry never fires
assign hit = enable & valid & (addr == match_at);
endmodule
`default_nettype wire

// [verif/icv_sva.sv]
// Checker on the icv_top ports: trap vectors and the take handshake.
// Assumes bind to icv_top, one clock, synchronous reset.
`timescale 1ns/1ps
`default_nettype none
`include "icv_defs.vh"
module icv_sva (
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        avs_waitrequest,
    input wire logic        illegal_op_instruction,
    input wire logic        overflow_trap_instruction,
    input wire logic        breakpoint_trap_instruction,
    input wire logic        numbered_trap_instruction,
    input wire logic [5:0]  trap_number,
    input wire logic        overflow_flag,
    input wire logic        stack_select_flag,
    input wire logic [19:0] relocatable_base,
    input wire logic        take_ack,
    input wire logic        take_valid,
    input wire logic [19:0] vector_addr_ff,
    input wire logic        non_maskable_ff,
    input wire logic        push_stack_flag_ff,
    input wire logic        stack_select_ff
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    wire ovf_hit = overflow_trap_instruction & overflow_flag;
    wire num_hit = numbered_trap_instruction & ~illegal_op_instruction & ~ovf_hit
                   & ~breakpoint_trap_instruction;
    ////////////////////////////////////////
    AST_UND: assert property (
        $rose(take_valid) && $past(illegal_op_instruction)
        |-> vector_addr_ff == `ICV_VEC_UNDEF && non_maskable_ff) else $error("Bad undef vector");
    AST_OVF: assert property (
        $rose(take_valid) && $past(ovf_hit && !illegal_op_instruction)
        |-> vector_addr_ff == `ICV_VEC_OVF) else $error("Bad overflow vector");
    AST_BRK: assert property (
        $rose(take_valid) && $past(breakpoint_trap_instruction && !illegal_op_instruction
        && !ovf_hit) |-> vector_addr_ff == `ICV_VEC_BRK) else $error("Bad break vector");
    AST_NUMLO: assert property (
        $rose(take_valid) && $past(num_hit && !trap_number[5]) |-> push_stack_flag_ff
        && !stack_select_ff && vector_addr_ff == $past(relocatable_base)
        + {12'h000, $past(trap_number), 2'b00}) else $error("Bad low trap take");
    AST_NUMHI: assert property (
        $rose(take_valid) && $past(num_hit && trap_number[5]) |-> !push_stack_flag_ff
        && stack_select_ff == $past(stack_select_flag)) else $error("Bad high trap take");
    AST_HOLD: assert property (
        take_valid && !take_ack |=> take_valid && $stable(vector_addr_ff))
        else $error("Take dropped early");
    AST_DONE: assert property (
        take_valid && take_ack |=> !take_valid) else $error("Take not ended");
    AST_WAIT: assert property (
        avs_waitrequest == 1'b0) else $error("Waitrequest raised");
endmodule
bind icv_top icv_sva u_sva (.*);
`default_nettype wire

// [verif/icv_seq_model.sv]
// Sequencer stand-in: accepts each take after a chosen delay.
// Assumes take_valid stands until the acknowledge edge.
`timescale 1ns/1ps
`default_nettype none
module icv_seq_model (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       take_valid,
    input  wire logic [1:0] slow,
    output var  logic       take_ack
);
    logic [1:0] wait_ff;
    ////////////////////////////////////////
    // One ack pulse per take; delay varies to stress the hold
    always @(posedge clk) begin
        if (sys_rst || !take_valid || take_ack) begin
            wait_ff  <= 2'h0;
            take_ack <= 1'b0;
        end else begin
            wait_ff  <= wait_ff + 2'h1;
            take_ack <= (wait_ff == slow);
        end
    end
endmodule
`default_nettype wire

// [verif/icv_top_tb.sv]
// Self-checking bench for icv_top: traps, special and peripheral takes.
// Assumes icv_seq_model acks takes and icv_sva is bound to the dut.
`timescale 1ns/1ps
`default_nettype none
`include "icv_defs.vh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin miscompares++; \
    $display("ERROR %0t got %h exp %h", $time, g, e); end end
module icv_top_tb;
    logic clk = 1'b0, sys_rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
    logic avs_waitrequest, take_valid, take_ack, non_maskable_ff, push_stack_flag_ff;
    logic vector_fixed_ff, stack_select_ff, irq, instr_valid = 1'b0, nmi_pin = 1'b1;
    logic illegal_op_instruction = 1'b0, overflow_trap_instruction = 1'b0;
    logic breakpoint_trap_instruction = 1'b0, numbered_trap_instruction = 1'b0;
    logic overflow_flag = 1'b0, interrupt_enable_flag = 1'b0, stack_select_flag = 1'b0;
    logic return_from_interrupt = 1'b0, restored_stack_flag = 1'b0, watchdog_request = 1'b0;
    logic debugger_break_request = 1'b0, single_step_request = 1'b0, osc_stop_event = 1'b0;
    logic periph_request = 1'b0;
    logic [3:0]  avs_address = 4'h0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, d;
    logic [19:0] vector_addr_ff, instr_addr = 20'h0, relocatable_base = 20'h0, b;
    logic [5:0]  trap_number = 6'h00, n;
    logic [4:0]  periph_number = 5'h00;
    logic [2:0]  cpu_priority_level = 3'h3, periph_level = 3'h0;
    logic [1:0]  slow = 2'h0;
    logic [15:0] lf = 16'h0061;
    int          compares = 0, miscompares = 0, i;
    icv_top dut (.*);
    icv_seq_model u_seq (.clk(clk), .sys_rst(sys_rst), .take_valid(take_valid),
                         .slow(slow), .take_ack(take_ack));
    always #25 clk = ~clk;
    ////////////////////////////////////////
    function automatic logic [15:0] nx(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    function automatic logic [19:0] rel(input logic [19:0] base, input logic [5:0] k);
        return base + {12'h000, k, 2'b00};
    endfunction
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] wd);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= wd;
        avs_write <= w;
        avs_read <= ~w;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        d = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    // Waits for the acknowledged take; bounded so a lost take fails
    task automatic take(input logic [19:0] ev, input logic nm);
        int k;
        k = 0;
        slow <= lf[1:0];
        // Look mid-cycle so the take is not raced at its launching edge
        do begin
            @(negedge clk);
            k++;
        end while (!(take_valid === 1'b1 && take_ack === 1'b1) && k < 40);
        `CHK(take_valid, 1'b1)
        `CHK(vector_addr_ff, ev)
        `CHK(non_maskable_ff, nm)
        @(posedge clk);
    endtask
    task automatic clr;
        {illegal_op_instruction, overflow_trap_instruction, breakpoint_trap_instruction} <= 3'h0;
        {numbered_trap_instruction, overflow_flag, watchdog_request, periph_request} <= 4'h0;
        {instr_valid, interrupt_enable_flag} <= 2'h0;
        {debugger_break_request, single_step_request} <= 2'h0;
        nmi_pin <= 1'b1;
        lf = nx(lf);
        @(posedge clk);
    endtask
    task automatic tally_and_finish;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        #(5000 * 50);
        miscompares++;
        tally_and_finish;
    end
    initial begin
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        `CHK(vector_addr_ff, `ICV_VEC_RESET)
        for (i = 0; i < 3; i++) begin
            illegal_op_instruction <= (i == 0);
            overflow_trap_instruction <= (i == 1);
            overflow_flag <= 1'b1;
            breakpoint_trap_instruction <= (i == 2);
            take(i == 0 ? `ICV_VEC_UNDEF : i == 1 ? `ICV_VEC_OVF : `ICV_VEC_BRK, 1'b1);
            `CHK(vector_fixed_ff, 1'b1)
            clr;
        end
        overflow_trap_instruction <= 1'b1;
        repeat (4) @(posedge clk);
        `CHK(take_valid, 1'b0)
        clr;
        for (i = 0; i < 12; i++) begin
            n = i < 4 ? {i[1], {5{i[0]}}} : lf[5:0];
            b = {lf, 4'h0};
            {relocatable_base, trap_number, stack_select_flag} <= {b, n, lf[6]};
            numbered_trap_instruction <= 1'b1;
            take(rel(b, n), 1'b1);
            `CHK(push_stack_flag_ff, ~n[5])
            `CHK(stack_select_ff, n[5] & lf[6])
            `CHK(vector_fixed_ff, 1'b0)
            clr;
        end
        // Return restores the stacked flag over the live one
        {return_from_interrupt, restored_stack_flag, stack_select_flag} <= 3'b110;
        @(posedge clk);
        return_from_interrupt <= 1'b0;
        @(negedge clk);
        `CHK(stack_select_ff, 1'b1)
        @(posedge clk);
        nmi_pin <= 1'b0;
        take(`ICV_VEC_NMI, 1'b1);
        clr;
        watchdog_request <= 1'b1;
        take(`ICV_VEC_OSC_WDT, 1'b1);
        clr;
        // Special requests are taken with the enable flag low
        debugger_break_request <= 1'b1;
        take(`ICV_VEC_DBG, 1'b1);
        clr;
        single_step_request <= 1'b1;
        take(`ICV_VEC_SSTEP, 1'b1);
        clr;
        for (i = 0; i < 3; i++) begin
            osc_stop_event <= 1'b1;
            @(posedge clk);
            osc_stop_event <= 1'b0;
            if (i == 1) begin
                repeat (4) @(posedge clk);
                `CHK(take_valid, 1'b0)
                bus(1'b1, `ICV_REG_OSC_FLAG, 32'h0);
            end else begin
                take(`ICV_VEC_OSC_WDT, 1'b1);
                bus(1'b0, `ICV_REG_OSC_FLAG, 32'h0);
                `CHK(d[0], 1'b1)
            end
        end
        bus(1'b0, `ICV_REG_STATUS, 32'h0);
        `CHK(d[5:0], 6'h0f)
        `CHK(irq, 1'b0)
        bus(1'b1, `ICV_REG_ENABLE, 32'h3f);
        @(posedge clk);
        `CHK(irq, 1'b1)
        bus(1'b1, `ICV_REG_CLEAR, 32'h3f);
        @(posedge clk);
        `CHK(irq, 1'b0)
        bus(1'b0, 4'hf, 32'h0);
        `CHK(d, 32'h0)
        bus(1'b1, `ICV_REG_MATCH2, {12'h000, lf, 4'h2});
        bus(1'b1, `ICV_REG_MATCH_EN, 32'h4);
        {instr_addr, instr_valid} <= {lf, 4'h2, 1'b1};
        take(`ICV_VEC_AMATCH, 1'b1);
        clr;
        b = {lf, 4'h0};
        {relocatable_base, periph_number, periph_request} <= {b, lf[4:0], 1'b1};
        for (i = 0; i < 2; i++) begin
            interrupt_enable_flag <= i[0];
            periph_level <= 3'h4 - i[2:0];
            repeat (4) @(posedge clk);
            `CHK(take_valid, 1'b0)
        end
        periph_level <= 3'h4;
        take(rel(b, {1'b0, lf[4:0]}), 1'b0);
        clr;
        tally_and_finish;
    end
endmodule
`default_nettype wire
